// File: design/lcd_host_consts.vh
`ifndef LCD_HOST_CONSTS_VH
`define LCD_HOST_CONSTS_VH

// Clock
`define CLK_PERIOD_NS     20

// Bus timing, in ns as printed
`define T_CYCLE_NS        500
`define T_EHIGH_NS        220
`define T_SETUP_NS        40
`define T_HOLD_NS         10

// Cycle counts, least times rounded up
`define CYC_SETUP  ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_EHIGH  ((`T_EHIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD   ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_CYCLE  ((`T_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_GAP    (`CYC_CYCLE - `CYC_SETUP - `CYC_EHIGH - `CYC_HOLD)

// Register byte offsets
`define REG_CMD_OFS       8'h00
`define REG_STATUS_OFS    8'h04
`define REG_CTRL_OFS      8'h08

// Command register fields
`define CMD_DATA_MSB      7
`define CMD_TARGET_BIT    8
`define CMD_DIR_BIT       9

// Status register fields
`define ST_ACTIVE_BIT     0
`define ST_DEV_BUSY_BIT   1
`define ST_DATA_LSB       8
`define ST_ADDR_LSB       16

// Control register fields
`define CTRL_POLL_BIT     0

// Device bus levels
`define DIR_READ          1'b1
`define DIR_WRITE         1'b0
`define TARGET_DATA       1'b1
`define TARGET_COMMAND    1'b0
`define BUSY_FLAG_BIT     7

`define CTRL_RESET        1'h0

`endif

// File: design/lcd_host.v
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "lcd_host_consts.vh"

module lcd_host #(
   parameter CNT_W = 5
) (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Display bus
   output reg         display_target_select,
   output reg         display_dir_select,
   output reg         display_strobe,
   input  wire [7:0]  display_data_in,
   output reg  [7:0]  display_data_out,
   output reg         display_data_oe
);

   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_SETUP = 5'h02;
   localparam [4:0] S_HIGH  = 5'h04;
   localparam [4:0] S_HOLD  = 5'h08;
   localparam [4:0] S_GAP   = 5'h10;

   // Counts worked out at full width; a count above CNT_W bits would wrap
   localparam integer SETUP_I = `CYC_SETUP;
   localparam integer EHIGH_I = `CYC_EHIGH;
   localparam integer HOLD_I  = `CYC_HOLD;
   localparam integer GAP_I   = `CYC_GAP;

   localparam [CNT_W-1:0] N_SETUP = SETUP_I[CNT_W-1:0];
   localparam [CNT_W-1:0] N_EHIGH = EHIGH_I[CNT_W-1:0];
   localparam [CNT_W-1:0] N_HOLD  = HOLD_I[CNT_W-1:0];
   localparam [CNT_W-1:0] N_GAP   = GAP_I[CNT_W-1:0];
   localparam [CNT_W-1:0] N_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};

   reg [4:0]       state_reg;
   reg [CNT_W-1:0] cnt_reg;
   reg             poll_en_reg;
   reg             polling_reg;
   reg             op_target_reg;
   reg             op_dir_reg;
   reg [7:0]       op_data_reg;
   reg [7:0]       rd_data_reg;
   reg             dev_busy_reg;

   wire acc        = psel & penable & pready;
   wire wr_cmd     = acc & pwrite & (paddr == `REG_CMD_OFS);
   wire wr_ctrl    = acc & pwrite & (paddr == `REG_CTRL_OFS);
   wire idle       = (state_reg == S_IDLE);
   wire cnt_done   = (cnt_reg == N_ONE);

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `REG_CMD_OFS) || (a == `REG_STATUS_OFS) || (a == `REG_CTRL_OFS);
      end
   endfunction

   function [CNT_W-1:0] cnt_dec;
      input [CNT_W-1:0] c;
      begin
         cnt_dec = c - N_ONE;
      end
   endfunction

   function host_drives;
      input dir;
      begin
         host_drives = (dir == `DIR_WRITE);
      end
   endfunction

   // APB answer one cycle into the access phase
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped(paddr);
         prdata  <= 32'h0000_0000;
         if (psel & penable & ~pready & ~pwrite) begin
            if (paddr == `REG_STATUS_OFS) begin
               prdata[`ST_ACTIVE_BIT]             <= ~idle;
               prdata[`ST_DEV_BUSY_BIT]           <= dev_busy_reg;
               prdata[`ST_DATA_LSB+7:`ST_DATA_LSB] <= rd_data_reg;
               prdata[`ST_ADDR_LSB+6:`ST_ADDR_LSB] <= rd_data_reg[6:0];
            end else if (paddr == `REG_CTRL_OFS) begin
               prdata[`CTRL_POLL_BIT] <= poll_en_reg;
            end
         end
      end
   end

   // Control register
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         poll_en_reg <= `CTRL_RESET;
      else if (wr_ctrl)
         poll_en_reg <= pwdata[`CTRL_POLL_BIT];
   end

   // Display bus sequencer; commands written while active are dropped
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg             <= S_IDLE;
         cnt_reg               <= {CNT_W{1'b0}};
         polling_reg           <= 1'b0;
         op_target_reg         <= `TARGET_COMMAND;
         op_dir_reg            <= `DIR_WRITE;
         op_data_reg           <= 8'h00;
         rd_data_reg           <= 8'h00;
         dev_busy_reg          <= 1'b0;
         display_target_select <= `TARGET_COMMAND;
         display_dir_select    <= `DIR_WRITE;
         display_strobe        <= 1'b0;
         display_data_out      <= 8'h00;
         display_data_oe       <= 1'b0;
      end else begin
         case (state_reg)
            S_IDLE: begin
               if (wr_cmd) begin
                  op_data_reg   <= pwdata[`CMD_DATA_MSB:0];
                  op_target_reg <= pwdata[`CMD_TARGET_BIT];
                  op_dir_reg    <= pwdata[`CMD_DIR_BIT];
                  polling_reg   <= poll_en_reg;
                  if (poll_en_reg) begin
                     // Busy poll is a command read
                     display_target_select <= `TARGET_COMMAND;
                     display_dir_select    <= `DIR_READ;
                     display_data_oe       <= 1'b0;
                  end else begin
                     display_target_select <= pwdata[`CMD_TARGET_BIT];
                     display_dir_select    <= pwdata[`CMD_DIR_BIT];
                     display_data_out      <= pwdata[`CMD_DATA_MSB:0];
                     display_data_oe       <= host_drives(pwdata[`CMD_DIR_BIT]);
                  end
                  cnt_reg   <= N_SETUP;
                  state_reg <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt_done) begin
                  display_strobe <= 1'b1;
                  cnt_reg        <= N_EHIGH;
                  state_reg      <= S_HIGH;
               end else
                  cnt_reg <= cnt_dec(cnt_reg);
            end
            S_HIGH: begin
               if (cnt_done) begin
                  // Sample late in the high phase, past the read delay
                  if (display_dir_select == `DIR_READ) begin
                     if (polling_reg)
                        dev_busy_reg <= display_data_in[`BUSY_FLAG_BIT];
                     else
                        rd_data_reg <= display_data_in;
                  end
                  display_strobe <= 1'b0;
                  cnt_reg        <= N_HOLD;
                  state_reg      <= S_HOLD;
               end else
                  cnt_reg <= cnt_dec(cnt_reg);
            end
            S_HOLD: begin
               if (cnt_done) begin
                  display_data_oe <= 1'b0;
                  cnt_reg         <= N_GAP;
                  state_reg       <= S_GAP;
               end else
                  cnt_reg <= cnt_dec(cnt_reg);
            end
            S_GAP: begin
               // Gap keeps the enable cycle time between strobes
               if (cnt_done) begin
                  cnt_reg   <= N_SETUP;
                  state_reg <= S_SETUP;
                  if (polling_reg && dev_busy_reg) begin
                     state_reg <= S_SETUP;
                  end else if (polling_reg) begin
                     polling_reg           <= 1'b0;
                     display_target_select <= op_target_reg;
                     display_dir_select    <= op_dir_reg;
                     display_data_out      <= op_data_reg;
                     display_data_oe       <= host_drives(op_dir_reg);
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end else
                  cnt_reg <= cnt_dec(cnt_reg);
            end
            default: begin
               state_reg      <= S_IDLE;
               display_strobe <= 1'b0;
               display_data_oe <= 1'b0;
            end
         endcase
      end
   end

endmodule // lcd_host

// File: verif/lcd_host_checker.sv
`timescale 1ns/100ps
module lcd_host_checker (
   // Clock and reset
   input wire       sys_clk,
   input wire       resetn,
   // Watched outputs
   input wire       pslverr,
   input wire       display_target_select,
   input wire       display_dir_select,
   input wire       display_strobe,
   input wire [7:0] display_data_out,
   input wire       display_data_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   AST_OE_DIR:
      assert property ($rose(display_strobe) |-> display_data_oe == !display_dir_select)
      else $error("oe does not follow direction");
   AST_SEL_SETUP:
      assert property ($rose(display_strobe) |-> display_target_select ==
         $past(display_target_select, 2) && display_dir_select == $past(display_dir_select, 2))
      else $error("selects not set up two cycles ahead");
   AST_SEL_STABLE:
      assert property (display_strobe |-> $stable(display_target_select) &&
         $stable(display_dir_select)) else $error("selects move under strobe");
   AST_DATA_HOLD:
      assert property (display_strobe && !display_dir_select |=> $stable(display_data_out))
      else $error("write data moves before strobe fall");
   AST_STB_WIDTH:
      assert property ($rose(display_strobe) |->
         display_strobe[*8] ##1 display_strobe[*3] ##1 !display_strobe)
      else $error("strobe width not eleven cycles");
   AST_STB_GAP:
      assert property ($fell(display_strobe) |-> !display_strobe[*8] ##1 !display_strobe[*6])
      else $error("strobe cycle too short");
   AST_OE_RELEASE:
      assert property ($fell(display_strobe) |->
         display_data_oe == !display_dir_select ##1 !display_data_oe)
      else $error("bus not released after hold");
   AST_OE_READ:
      assert property (display_data_oe |-> !display_dir_select) else $error("oe on a read");
   cover property ($rose(display_strobe) && display_dir_select);
   cover property ($rose(display_strobe) && display_target_select);
   cover property (pslverr);
endmodule // lcd_host_checker

bind lcd_host lcd_host_checker checker_inst (.sys_clk(sys_clk), .resetn(resetn),
   .pslverr(pslverr), .display_target_select(display_target_select),
   .display_dir_select(display_dir_select), .display_strobe(display_strobe),
   .display_data_out(display_data_out), .display_data_oe(display_data_oe));

// File: verif/lcd_dev_model.sv
`timescale 1ns/100ps
module lcd_dev_model #(
   parameter BUSY_NS = 2000
) (
   // Display bus
   input  wire       target,
   input  wire       dir,
   input  wire       strobe,
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output wire       data_oe
);
   localparam GLYPH_ROM_N = 208;
   localparam GLYPH_RAM_N = 8;
   reg  [7:0] text_ram [0:127];
   reg  [6:0] addr_reg = 7'h00;
   reg  [5:0] shift_reg = 6'h00;
   time       busy_until = 0;
   initial data_out = 8'h5A;
   assign data_oe = strobe & dir;
   // Address shown at a screen position; window wraps over 40 locations
   function [6:0] pos_addr(input row, input [3:0] col);
      pos_addr = {row, 6'h00} + (col + shift_reg) % 6'h28;
   endfunction
   always @(posedge strobe) begin
      if (dir)
         data_out = target ? text_ram[addr_reg] : {$time < busy_until, addr_reg};
   end
   always @(negedge strobe) begin
      if (!dir)
         busy_until = $time + BUSY_NS;
      if (target) begin
         if (!dir)
            text_ram[addr_reg] = data_in;
         addr_reg = addr_reg + 7'h01;
      end else if (!dir && data_in[7])
         addr_reg = data_in[6:0];
      else if (!dir && data_in[7:3] == 5'h03)
         shift_reg = (shift_reg + (data_in[2] ? 6'h27 : 6'h01)) % 7'h28;
   end
endmodule // lcd_dev_model

// File: verif/lcd_host_test.sv
`timescale 1ns/100ps
module lcd_host_test;
   reg         sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0, r;
   wire [31:0] prdata;
   wire        pready, pslverr, tsel, dsel, stb, h_oe, d_oe;
   wire [7:0]  h_out, d_out;
   // Released bus shows the inverse, so stale data never passes
   wire [7:0]  bus = d_oe ? d_out : h_oe ? h_out : ~d_out;
   reg         e;
   integer     n_errors = 0, compares = 0;
   lcd_host lcd_host_inst (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .display_target_select(tsel), .display_dir_select(dsel),
      .display_strobe(stb), .display_data_in(bus),
      .display_data_out(h_out), .display_data_oe(h_oe));
   lcd_dev_model lcd_dev_model_inst (.target(tsel), .dir(dsel), .strobe(stb),
      .data_in(h_out), .data_out(d_out), .data_oe(d_oe));
   initial forever #10 sys_clk = ~sys_clk;
   task chk(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         n_errors = n_errors + 1;
      end
   endtask
   always @(posedge sys_clk)
      if (h_oe === 1'b1)
         chk(d_oe, 1'b0);
   // Request held until the edge at which pready is seen high
   task apb(input w, input [7:0] a, input [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
         @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Waits on the host, not the device; device busy is the host's job
   task cmd(input [9:0] c);
      apb(1'b1, 8'h00, {22'h0, c});
      do
         apb(1'b0, 8'h04, 32'h0);
      while (r[0] !== 1'b0);
   endtask
   task t_regs;
      apb(1'b0, 8'h08, 32'h0);
      chk(r, 32'h0);
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(r, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk({r[30:0], e}, 32'h1);
   endtask
   task t_write_text;
      cmd(10'h0C0);
      cmd(10'h141); cmd(10'h1FF);
      cmd(10'h200);
      chk(r[22:8], {7'h42, 8'h42});
      chk(r[1], 1'b0);
   endtask
   task t_read_text;
      cmd(10'h0C0); cmd(10'h300);
      chk(r[15:8], 8'h41);
      cmd(10'h300);
      chk(r[15:8], 8'hFF);
   endtask
   task t_no_poll;
      apb(1, 8'h08, 32'h0);
      cmd(10'h080); cmd(10'h200);
      chk(r[15:8], 8'h80);
   endtask
   task t_shift;
      chk(lcd_dev_model_inst.pos_addr(1'b0, 4'hF), 32'h0F);
      chk(lcd_dev_model_inst.pos_addr(1'b1, 4'h0), 32'h40);
      cmd(10'h018);
      chk(lcd_dev_model_inst.pos_addr(1'b0, 4'h0), 32'h01);
      chk(lcd_dev_model_inst.pos_addr(1'b1, 4'hF), 32'h50);
      cmd(10'h01C);
      cmd(10'h01C);
      chk(lcd_dev_model_inst.pos_addr(1'b0, 4'h0), 32'h27);
      chk(lcd_dev_model_inst.pos_addr(1'b1, 4'h1), 32'h40);
   endtask
   task test_done;
      if (n_errors == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #1000000 n_errors = n_errors + 1;
      test_done;
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1;
      t_regs; t_write_text; t_read_text; t_shift; t_no_poll;
      test_done;
   end
endmodule // lcd_host_test
